// ===== clksw_defs.svh
`ifndef CLKSW_DEFS_SVH
`define CLKSW_DEFS_SVH

// register offsets
`define CLKSW_OFS_MULT 4'h0
`define CLKSW_OFS_TRIM 4'h1
`define CLKSW_OFS_CTRL 4'h2
`define CLKSW_OFS_KEY 4'h3

// reset values
`define CLKSW_MULT_RST 9'h030
`define CLKSW_TRIM_RST 6'h00
`define CLKSW_CUR_RST 3'h0

// field layout
`define CLKSW_MULT_W 9
`define CLKSW_TRIM_W 6
`define CLKSW_CUR_LSB 12
`define CLKSW_REQ_LSB 8
`define CLKSW_SWREQ_BIT 0
`define CLKSW_SRC_W 3

// unlock keys, written in this order to the key register
`define CLKSW_KEY1 16'h0055
`define CLKSW_KEY2 16'h00AA

// source codes
`define CLKSW_SRC_FRC 3'h0
`define CLKSW_SRC_PRI 3'h2
`define CLKSW_SRC_LPX 3'h4
`define CLKSW_SRC_SLOW_RC_SOURCE 3'h5

// new-clock cycles to wait before the changeover
`define CLKSW_SETTLE_CYC 4'hA

`endif

// ===== clksw_pkg.sv
package clksw_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } clksw_bus_req_type;

  typedef enum logic [1:0] {
    CLKSW_IDLE,
    CLKSW_WAIT_READY,
    CLKSW_SETTLE
  } clksw_state_type;

endpackage

// ===== clksw_settle.sv
`timescale 1ns/10ps
`include "clksw_defs.svh"

module clksw_settle
  import clksw_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // control
  input wire logic start_i,
  input wire logic ready_i,
  input wire logic newclk_i,
  // status
  output logic ready_o,
  output logic done_o
);

  logic [1:0] rdy_sync;
  logic [1:0] clk_sync;
  logic clk_last;
  logic active;
  logic [3:0] edges;

  // two flops before anything looks at the pins
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdy_sync <= 2'h0;
      clk_sync <= 2'h0;
      clk_last <= 1'b0;
    end
    else if (ce_i)
    begin
      rdy_sync <= {rdy_sync[0], ready_i};
      clk_sync <= {clk_sync[0], newclk_i};
      clk_last <= clk_sync[1];
    end
  end

  assign ready_o = rdy_sync[1];

  // new clock must run below half of mclk or edges are missed
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      active <= 1'b0;
      edges <= 4'h0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        active <= 1'b1;
        edges <= 4'h0;
      end
      else if (active && clk_sync[1] && !clk_last)
      begin
        if (edges == `CLKSW_SETTLE_CYC - 4'h1)
        begin
          active <= 1'b0;
          done_o <= 1'b1;
        end
        else
          edges <= edges + 4'h1;
      end
    end
  end

endmodule

// ===== clksw_top.sv
// How it works
// - the multiplier field is nine writable bits, upper bits read zero, n multiplies by n+2.
// - after reset the multiplier field gives a factor of 50.
// - the trim field is six writable bits resetting to zero, upper bits read zero.
// - the trim field is a signed offset in 0.375 percent steps around nominal.
// - software may pick any of the four clock sources; a pick written mid-switch before the completion cycle is cleared unserved.
// - control register writes need a fresh key sequence before each one.
// - the primary submode comes from a two-bit strap and never changes at run time.
// - switching to and from primary is allowed, switching primary submodes is not.
// - setting the switch request starts a switch, completion clears it and copies the source.
// - a request for the source already in use is aborted and cleared.
// - after the new source is ready, ten new-clock cycles pass before changeover.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "clksw_defs.svh"

module clksw_top
  import clksw_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // register port
  input wire clksw_bus_req_type bus_i,
  output logic [15:0] rdata_o,
  // straps and oscillator status
  input wire logic [1:0] primary_submode_cfg_i,
  input wire logic src_ready_i,
  input wire logic newclk_i,
  // clock control outputs
  output logic [`CLKSW_MULT_W-1:0] multiplier_field_o,
  output logic [`CLKSW_TRIM_W-1:0] trim_field_o,
  output logic [1:0] primary_submode_o,
  output logic [`CLKSW_SRC_W-1:0] current_source_o,
  output logic [`CLKSW_SRC_W-1:0] target_source_o,
  output logic target_enable_o
);

  clksw_state_type state;
  logic [1:0] cfg_sync0;
  logic [1:0] cfg_sync1;
  logic [1:0] cfg_age;
  logic [`CLKSW_SRC_W-1:0] requested_source_field;
  logic switch_request_bit;
  logic [1:0] key_stage;
  logic unlocked;
  logic ctrl_wr;
  logic settle_start;
  logic settle_done;
  logic new_ready;
  logic hw_clear;
  logic valid_req;

  assign ctrl_wr = bus_i.we && (bus_i.addr == `CLKSW_OFS_CTRL);

  // strap caught once after reset release, through two flops
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_sync0 <= 2'h0;
      cfg_sync1 <= 2'h0;
      cfg_age <= 2'h0;
      primary_submode_o <= 2'h0;
    end
    else if (ce_i)
    begin
      cfg_sync0 <= primary_submode_cfg_i;
      cfg_sync1 <= cfg_sync0;
      // wait out both sync flops, else the reset value is caught
      if (cfg_age != 2'h3)
        cfg_age <= cfg_age + 2'h1;
      if (cfg_age == 2'h2)
        primary_submode_o <= cfg_sync1;
    end
  end

  // plain settings registers
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      multiplier_field_o <= `CLKSW_MULT_RST;
      trim_field_o <= `CLKSW_TRIM_RST;
    end
    else if (ce_i && bus_i.we)
    begin
      if (bus_i.addr == `CLKSW_OFS_MULT)
        multiplier_field_o <= bus_i.wdata[`CLKSW_MULT_W-1:0];
      else if (bus_i.addr == `CLKSW_OFS_TRIM)
        trim_field_o <= bus_i.wdata[`CLKSW_TRIM_W-1:0];
    end
  end

  // key sequence; any other write breaks it, one control write uses it
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      key_stage <= 2'h0;
      unlocked <= 1'b0;
    end
    else if (ce_i && bus_i.we)
    begin
      if (bus_i.addr == `CLKSW_OFS_KEY && bus_i.wdata == `CLKSW_KEY1)
      begin
        key_stage <= 2'h1;
        unlocked <= 1'b0;
      end
      else if (bus_i.addr == `CLKSW_OFS_KEY && key_stage == 2'h1
               && bus_i.wdata == `CLKSW_KEY2)
      begin
        key_stage <= 2'h0;
        unlocked <= 1'b1;
      end
      else
      begin
        key_stage <= 2'h0;
        unlocked <= 1'b0;
      end
    end
  end

  // requested source; locked writes fall on the floor
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      requested_source_field <= `CLKSW_CUR_RST;
    else if (ce_i && ctrl_wr && unlocked)
      requested_source_field <=
        bus_i.wdata[`CLKSW_REQ_LSB+`CLKSW_SRC_W-1:`CLKSW_REQ_LSB];
  end

  // only the four documented codes; the submode is not selectable here
  always_comb
  begin
    valid_req = (requested_source_field == `CLKSW_SRC_FRC) ||
                (requested_source_field == `CLKSW_SRC_PRI) ||
                (requested_source_field == `CLKSW_SRC_LPX) ||
                (requested_source_field == `CLKSW_SRC_SLOW_RC_SOURCE);
  end

  always_comb
  begin
    hw_clear = 1'b0;
    settle_start = 1'b0;
    case (state)
      CLKSW_IDLE:
        if (switch_request_bit)
        begin
          if (requested_source_field == current_source_o || !valid_req)
            hw_clear = 1'b1;
        end
      CLKSW_WAIT_READY:
        settle_start = new_ready;
      CLKSW_SETTLE:
        hw_clear = settle_done;
      default:
        hw_clear = 1'b0;
    endcase
  end

  // software set wins over a same-cycle hardware clear
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      switch_request_bit <= 1'b0;
    else if (ce_i)
    begin
      if (ctrl_wr && unlocked && bus_i.wdata[`CLKSW_SWREQ_BIT])
        switch_request_bit <= 1'b1;
      else if (hw_clear)
        switch_request_bit <= 1'b0;
    end
  end

  // switch sequencer; target held so mid-switch writes cannot tear it
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= CLKSW_IDLE;
      current_source_o <= `CLKSW_CUR_RST;
      target_source_o <= `CLKSW_CUR_RST;
      target_enable_o <= 1'b0;
    end
    else if (ce_i)
    begin
      case (state)
        CLKSW_IDLE:
          if (switch_request_bit && !hw_clear)
          begin
            target_source_o <= requested_source_field;
            target_enable_o <= 1'b1;
            state <= CLKSW_WAIT_READY;
          end
        CLKSW_WAIT_READY:
          if (new_ready)
            state <= CLKSW_SETTLE;
        CLKSW_SETTLE:
          if (settle_done)
          begin
            current_source_o <= target_source_o;
            target_enable_o <= 1'b0;
            state <= CLKSW_IDLE;
          end
        default:
          state <= CLKSW_IDLE;
      endcase
    end
  end

  clksw_settle u_settle (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .start_i(settle_start),
    .ready_i(src_ready_i),
    .newclk_i(newclk_i),
    .ready_o(new_ready),
    .done_o(settle_done)
  );

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 16'h0000;
    else if (ce_i)
    begin
      rdata_o <= 16'h0000;
      if (bus_i.re)
      begin
        if (bus_i.addr == `CLKSW_OFS_MULT)
          rdata_o <= {7'h00, multiplier_field_o};
        else if (bus_i.addr == `CLKSW_OFS_TRIM)
          rdata_o <= {10'h000, trim_field_o};
        else if (bus_i.addr == `CLKSW_OFS_CTRL)
          rdata_o <= {1'b0, current_source_o, 1'b0,
                      requested_source_field, 7'h00,
                      switch_request_bit};
      end
    end
  end

endmodule

// ===== clksw_properties.sv
`timescale 1ns/10ps
`include "clksw_defs.svh"
module clksw_props
  import clksw_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // register port
  input wire clksw_bus_req_type bus_i,
  input wire logic [15:0] rdata_o,
  // control outputs
  input wire logic [8:0] multiplier_field_o,
  input wire logic [5:0] trim_field_o,
  input wire logic [1:0] primary_submode_o,
  input wire logic [2:0] current_source_o,
  input wire logic [2:0] target_source_o,
  input wire logic target_enable_o
);
  logic [2:0] up;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // age since reset, masks stale history after a reset
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  end
  rd_quiet_a: assert property ($past(ce_i) && !$past(bus_i.re)
    |-> rdata_o == 16'h0000) else $error("read data not idle");
  mult_wr_a: assert property (ce_i && bus_i.we && bus_i.addr == 4'h0
    |=> multiplier_field_o == $past(bus_i.wdata[8:0]))
    else $error("multiplier write lost");
  trim_wr_a: assert property (ce_i && bus_i.we && bus_i.addr == 4'h1
    |=> trim_field_o == $past(bus_i.wdata[5:0])) else $error("trim write lost");
  mult_rd_a: assert property (ce_i && bus_i.re && bus_i.addr == 4'h0
    |=> rdata_o == {7'h00, $past(multiplier_field_o)})
    else $error("multiplier read wrong");
  trim_rd_a: assert property (ce_i && bus_i.re && bus_i.addr == 4'h1
    |=> rdata_o == {10'h000, $past(trim_field_o)}) else $error("trim read wrong");
  sub_fixed_a: assert property (up == 3'h7 |-> $stable(primary_submode_o))
    else $error("submode changed");
  cur_move_a: assert property (up != 3'h0 && $changed(current_source_o)
    |-> $fell(target_enable_o) && current_source_o == $past(target_source_o))
    else $error("source changed outside changeover");
  tgt_hold_a: assert property (target_enable_o && $past(target_enable_o)
    |-> $stable(target_source_o)) else $error("target moved mid-switch");
  settle_a: assert property ($rose(target_enable_o)
    |=> target_enable_o [*8]) else $error("changeover too early");
  cover property ($fell(target_enable_o));
  cover property (bus_i.re && bus_i.addr == 4'h2);
  cover property (ce_i && bus_i.we && bus_i.addr == 4'h1);
endmodule
bind clksw_top clksw_props clksw_props_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .multiplier_field_o(multiplier_field_o), .trim_field_o(trim_field_o),
  .primary_submode_o(primary_submode_o), .current_source_o(current_source_o),
  .target_source_o(target_source_o), .target_enable_o(target_enable_o));

// ===== clksw_tb.sv
`timescale 1ns/10ps
`include "clksw_defs.svh"
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb
  import clksw_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce = 1'b1;
  clksw_bus_req_type bus_i = '0;
  logic [1:0] cfg = 2'h2;
  logic rdy = 1'b0;
  logic nclk = 1'b0;
  logic [15:0] rdata_o;
  logic [8:0] mult;
  logic [5:0] trim;
  logic [1:0] sub;
  logic [2:0] cur;
  logic [2:0] tgt;
  logic ten;
  logic [15:0] v;
  int err_total = 0;
  int check_count = 0;

  always #2.5 mclk_i = ~mclk_i;

  clksw_top clksw_top_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce),
    .bus_i(bus_i), .rdata_o(rdata_o), .primary_submode_cfg_i(cfg),
    .src_ready_i(rdy), .newclk_i(nclk), .multiplier_field_o(mult),
    .trim_field_o(trim), .primary_submode_o(sub), .current_source_o(cur),
    .target_source_o(tgt), .target_enable_o(ten));

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_i);
    bus_i <= '0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    bus_i <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk_i);
    bus_i <= '0;
    #1 d = rdata_o;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // slow clock, 2 high 2 low, stays low between bursts
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      nclk <= 1'b1;
      repeat (2) @(posedge mclk_i);
      nclk <= 1'b0;
      @(posedge mclk_i);
    end
    #1;
  endtask

  task automatic unlock;
    wr(4'h3, `CLKSW_KEY1);
    wr(4'h3, `CLKSW_KEY2);
  endtask

  task automatic t_reset;
    `CHK("mult", 9'h030, mult)
    rd(4'h0, v);
    `CHK("mult rd", 16'h0030, v)
    rd(4'h1, v);
    `CHK("trim rd", 16'h0000, v)
    @(posedge mclk_i);
    cfg <= 2'h1;
    idle(6);
    `CHK("sub", 2'h2, sub)
  endtask

  task automatic t_regs;
    wr(4'h0, 16'hFFFF);
    `CHK("mult", 9'h1FF, mult)
    rd(4'h0, v);
    `CHK("mult rd", 16'h01FF, v)
    wr(4'h1, 16'hFFE0);
    `CHK("trim", 6'h20, trim)
    rd(4'h1, v);
    `CHK("trim rd", 16'h0020, v)
    wr(4'h1, 16'h001E);
    `CHK("trim", 6'h1E, trim)
    rd(4'hF, v);
    `CHK("unmapped", 16'h0000, v)
  endtask

  // clock enable low must swallow a write
  task automatic t_freeze;
    @(posedge mclk_i);
    ce <= 1'b0;
    wr(4'h0, 16'h0005);
    `CHK("mult frozen", 9'h1FF, mult)
    @(posedge mclk_i);
    ce <= 1'b1;
    wr(4'h0, 16'h0005);
    `CHK("mult thawed", 9'h005, mult)
  endtask

  // locked write, then a key pair broken by another write
  task automatic t_lock;
    wr(4'h2, 16'h0201);
    idle(3);
    `CHK("en", 1'b0, ten)
    wr(4'h3, `CLKSW_KEY1);
    wr(4'h1, 16'h0000);
    wr(4'h3, `CLKSW_KEY2);
    wr(4'h2, 16'h0201);
    idle(3);
    `CHK("en", 1'b0, ten)
    rd(4'h2, v);
    `CHK("ctrl", 16'h0000, v)
  endtask

  task automatic t_abort;
    unlock;
    wr(4'h2, 16'h0001);
    idle(3);
    `CHK("en", 1'b0, ten)
    rd(4'h2, v);
    `CHK("req", 1'b0, v[0])
    unlock;
    wr(4'h2, 16'h0301);
    idle(3);
    `CHK("bad code en", 1'b0, ten)
    rd(4'h2, v);
    `CHK("bad code req", 1'b0, v[0])
  endtask

  task automatic t_switch(input logic [2:0] s, input logic [2:0] old);
    unlock;
    wr(4'h2, {5'h00, s, 8'h01});
    idle(2);
    `CHK("en", 1'b1, ten)
    `CHK("tgt", s, tgt)
    @(posedge mclk_i);
    rdy <= 1'b1;
    idle(4);
    pulse(9);
    idle(6);
    `CHK("cur early", old, cur)
    pulse(1);
    for (int i = 0; i < 10 && ten; i++) idle(1);
    `CHK("en", 1'b0, ten)
    `CHK("cur", s, cur)
    rd(4'h2, v);
    `CHK("ctrl", {1'b0, s, 1'b0, s, 8'h00}, v)
    @(posedge mclk_i);
    rdy <= 1'b0;
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #50000;
    err_total++;
    end_sim;
  end

  initial
  begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    idle(6);
    t_reset;
    t_regs;
    t_freeze;
    t_lock;
    t_abort;
    t_switch(3'h2, 3'h0);
    t_switch(3'h4, 3'h2);
    t_switch(3'h5, 3'h4);
    t_switch(3'h0, 3'h5);
    end_sim;
  end
endmodule
